// ### design/cmcr_pkg.sv
/*
  package of the mode control register: offsets, fields, reset values, mode codes.
  assumes a 16-bit register port with one-cycle read latency.
*/
package cmcr_pkg;

  localparam logic [3:0]  CTRL_ONE_OFFS   = 4'h0;
  localparam logic [3:0]  STATUS_OFFS     = 4'h1;

  localparam int          STOP_IDLE_BIT   = 13;
  localparam int          ABORT_BIT       = 12;
  localparam int          CLK_SEL_BIT     = 11;
  localparam int          REQ_LSB         = 8;
  localparam int          CUR_LSB         = 5;
  localparam int          CAP_BIT         = 3;
  localparam int          WIN_BIT         = 0;

  localparam logic [15:0] WRITE_MASK      = 16'h3F09;

  typedef enum logic [2:0] {
    CMCR_NORMAL   = 3'h0,
    CMCR_DISABLE  = 3'h1,
    CMCR_LOOPBACK = 3'h2,
    CMCR_LISTEN   = 3'h3,
    CMCR_CONFIG   = 3'h4,
    CMCR_RSVD_5   = 3'h5,
    CMCR_RSVD_6   = 3'h6,
    CMCR_LISTEN_ALL = 3'h7
  } cmcr_mode_t;

  localparam logic [2:0]  MODE_RESET      = 3'h4;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } cmcr_bus_t;

  typedef struct packed {
    logic stop_in_idle;
    logic module_clock_select;
    logic rx_capture_enable;
    logic filter_window;
  } cmcr_cfg_t;

endpackage : cmcr_pkg

// ### design/cmcr_mode_seq.sv
/*
  mode sequencer: moves the current mode to the requested one at a safe point.
  assumes bus_idle comes from the protocol engine, synchronous to mclk.
*/
`timescale 1ns/1ps
module cmcr_mode_seq (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [2:0] req_mode,
  input  wire logic       bus_idle,
  output logic [2:0]      cur_mode_q
);

  function automatic logic mode_legal(input logic [2:0] m);
    mode_legal = (m != 3'h5) && (m != 3'h6);
  endfunction : mode_legal

  wire logic change_ok;
  assign change_ok = mode_legal(req_mode) && (req_mode != cur_mode_q) && bus_idle;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cur_mode_q <= cmcr_pkg::MODE_RESET;
    end else if (change_ok) begin
      cur_mode_q <= req_mode;
    end
  end

  reserved_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !mode_legal(req_mode) |=> $stable(cur_mode_q))
    else $error("mode changed on reserved request");
  busy_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !bus_idle |=> $stable(cur_mode_q))
    else $error("mode changed while bus busy");

endmodule : cmcr_mode_seq

// ### design/cmcr_top.sv
/*
  mode control register of the can controller, with its register port.
  assumes a single-cycle strobe master; rx_msg, tx_pending, bus_idle and
  device_idle are synchronous to mclk.
*/
// Notes on behaviour
// - stop-in-idle halts module during device idle
// - abort-all write signals all transmit buffers
// - hardware clears abort bit when aborts done
// - clock select picks doubled or peripheral clock
// - requested mode field encodes six modes
// - current mode field reports effective mode
// - both mode fields reset to configuration
// - capture enable turns receives into capture events
// - window bit selects filter or buffer map
// - unimplemented bits ignore writes, read zero
`timescale 1ns/1ps
module cmcr_top (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        device_idle,
  input  wire logic        bus_idle,
  input  wire logic        rx_msg,
  input  wire logic        tx_pending,
  output logic [15:0]      reg_rdata_q,
  output logic             module_halt_q,
  output logic             abort_all_tx_q,
  output logic             module_clock_double_q,
  output logic             rx_capture_q,
  output logic             filter_window_q,
  output logic [2:0]       current_mode_q
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  cmcr_pkg::cmcr_bus_t bus;
  cmcr_pkg::cmcr_cfg_t cfg_q;
  logic [2:0]          requested_mode_q;
  logic                abort_q;
  logic [2:0]          cur_mode;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // address match is shared by the write and read decode
  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] offs);
    addr_hit = (a == offs);
  endfunction : addr_hit

  // reserved codes never become the mode in effect
  function automatic logic mode_is_legal(input logic [2:0] m);
    mode_is_legal = (m != 3'h5) && (m != 3'h6);
  endfunction : mode_is_legal

  wire logic        wr_ctrl;
  wire logic        rd_ctrl;
  wire logic        rd_status;
  wire logic        abort_set;
  wire logic        abort_clr;
  wire logic [15:0] wmask_data;
  wire logic [15:0] ctrl_view;
  wire logic [15:0] status_view;
  wire logic [15:0] rd_mux;

  assign wr_ctrl    = bus.wr && addr_hit(bus.addr, cmcr_pkg::CTRL_ONE_OFFS);
  assign rd_ctrl    = bus.rd && addr_hit(bus.addr, cmcr_pkg::CTRL_ONE_OFFS);
  assign rd_status  = bus.rd && addr_hit(bus.addr, cmcr_pkg::STATUS_OFFS);
  assign wmask_data = bus.wdata & cmcr_pkg::WRITE_MASK;
  assign abort_set  = wr_ctrl && wmask_data[cmcr_pkg::ABORT_BIT];
  // a set in the same cycle as completion wins, so no new abort is lost
  assign abort_clr  = abort_q && !tx_pending;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q            <= '0;
      requested_mode_q <= cmcr_pkg::MODE_RESET;
    end else if (wr_ctrl) begin
      cfg_q.stop_in_idle        <= wmask_data[cmcr_pkg::STOP_IDLE_BIT];
      cfg_q.module_clock_select <= wmask_data[cmcr_pkg::CLK_SEL_BIT];
      cfg_q.rx_capture_enable   <= wmask_data[cmcr_pkg::CAP_BIT];
      cfg_q.filter_window       <= wmask_data[cmcr_pkg::WIN_BIT];
      requested_mode_q          <= wmask_data[cmcr_pkg::REQ_LSB +: 3];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      abort_q <= 1'b0;
    end else if (abort_set) begin
      abort_q <= 1'b1;
    end else if (abort_clr) begin
      abort_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencing

  cmcr_mode_seq cmcr_mode_seq_inst (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .req_mode   (requested_mode_q),
    .bus_idle   (bus_idle),
    .cur_mode_q (cur_mode)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read port

  assign ctrl_view = {2'h0, cfg_q.stop_in_idle, abort_q, cfg_q.module_clock_select,
                      requested_mode_q, cur_mode, 1'b0, cfg_q.rx_capture_enable,
                      2'h0, cfg_q.filter_window};
  assign status_view = {13'h0000, cur_mode};
  assign rd_mux = rd_ctrl   ? ctrl_view :
                  rd_status ? status_view :
                  16'h0000;

  // halting only while idle keeps the module live when the cpu sleeps lightly
  wire logic halt_d;
  assign halt_d = cfg_q.stop_in_idle && device_idle;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q           <= 16'h0000;
      module_halt_q         <= 1'b0;
      abort_all_tx_q        <= 1'b0;
      module_clock_double_q <= 1'b0;
      rx_capture_q          <= 1'b0;
      filter_window_q       <= 1'b0;
      current_mode_q        <= cmcr_pkg::MODE_RESET;
    end else begin
      reg_rdata_q           <= rd_mux;
      module_halt_q         <= halt_d;
      abort_all_tx_q        <= abort_q;
      module_clock_double_q <= cfg_q.module_clock_select;
      rx_capture_q          <= rx_msg && cfg_q.rx_capture_enable;
      filter_window_q       <= cfg_q.filter_window;
      current_mode_q        <= cur_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  halt_follow_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (cfg_q.stop_in_idle && device_idle) |=> module_halt_q)
    else $error("module not halted in idle");
  abort_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    abort_set |=> abort_q ##1 abort_all_tx_q)
    else $error("abort request not signalled");
  abort_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (abort_q && !tx_pending && !abort_set) |=> !abort_q)
    else $error("abort bit not cleared");
  clk_sel_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_ctrl |=> ##1 (module_clock_double_q == $past(reg_wdata[11], 2)))
    else $error("clock select wrong");
  req_store_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_ctrl |=> (requested_mode_q == $past(reg_wdata[10:8])))
    else $error("requested mode not stored");
  mode_report_a: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1 |=> (current_mode_q == $past(cur_mode)))
    else $error("current mode output stale");
  capture_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (rx_msg && !cfg_q.rx_capture_enable) |=> !rx_capture_q)
    else $error("capture without enable");
  window_sel_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_ctrl |=> ##1 (filter_window_q == $past(reg_wdata[0], 2)))
    else $error("window select wrong");
  unimpl_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_rd && reg_addr == 4'h0) |=> ((reg_rdata_q & 16'hC016) == 16'h0000))
    else $error("unimplemented bits read nonzero");

  ////////////////////////////////////////////////////////////////////////////
  // read port checks: each field read back against its own state

  rd_idle_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !reg_rd |=> (reg_rdata_q == 16'h0000))
    else $error("read data not zero without read");

  rd_unmapped_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_rd && !rd_ctrl && !rd_status) |=> (reg_rdata_q == 16'h0000))
    else $error("unmapped read not zero");

  rd_status_mode_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_status |=> (reg_rdata_q == {13'h0000, $past(cur_mode)}))
    else $error("status read wrong");

  rd_req_field_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_ctrl |=> (reg_rdata_q[10:8] == $past(requested_mode_q)))
    else $error("requested mode read wrong");

  rd_cur_field_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_ctrl |=> (reg_rdata_q[7:5] == $past(cur_mode)))
    else $error("current mode read wrong");

  rd_abort_bit_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_ctrl |=> (reg_rdata_q[12] == $past(abort_q)))
    else $error("abort bit read wrong");

  rd_stop_bit_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_ctrl |=> (reg_rdata_q[13] == $past(cfg_q.stop_in_idle)))
    else $error("stop bit read wrong");

  rd_clk_bit_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_ctrl |=> (reg_rdata_q[11] == $past(cfg_q.module_clock_select)))
    else $error("clock select read wrong");

  rd_cap_bit_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_ctrl |=> (reg_rdata_q[3] == $past(cfg_q.rx_capture_enable)))
    else $error("capture bit read wrong");

  rd_win_bit_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_ctrl |=> (reg_rdata_q[0] == $past(cfg_q.filter_window)))
    else $error("window bit read wrong");

  ////////////////////////////////////////////////////////////////////////////
  // write checks

  stop_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_ctrl |=> (cfg_q.stop_in_idle == $past(reg_wdata[13])))
    else $error("stop bit not stored");

  clk_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_ctrl |=> (cfg_q.module_clock_select == $past(reg_wdata[11])))
    else $error("clock select not stored");

  cap_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_ctrl |=> (cfg_q.rx_capture_enable == $past(reg_wdata[3])))
    else $error("capture bit not stored");

  win_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_ctrl |=> (cfg_q.filter_window == $past(reg_wdata[0])))
    else $error("window bit not stored");

  req_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !wr_ctrl |=> $stable(requested_mode_q))
    else $error("requested mode changed without write");

  cfg_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !wr_ctrl |=> $stable(cfg_q))
    else $error("config changed without write");

  status_ro_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_wr && addr_hit(reg_addr, cmcr_pkg::STATUS_OFFS)) |=> $stable(requested_mode_q))
    else $error("status write changed mode request");

  ////////////////////////////////////////////////////////////////////////////
  // abort checks: a late clear must never swallow a fresh request

  abort_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (!abort_q && !abort_set) |=> !abort_q)
    else $error("abort set without request");

  abort_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (abort_q && tx_pending) |=> abort_q)
    else $error("abort cleared while pending");

  abort_wins_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (abort_q && abort_set) |=> abort_q)
    else $error("abort set lost to clear");

  abort_out_a: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1 |=> (abort_all_tx_q == $past(abort_q)))
    else $error("abort output not following bit");

  abort_zero_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_ctrl && !wmask_data[cmcr_pkg::ABORT_BIT] && abort_q && tx_pending) |=> abort_q)
    else $error("software cleared abort bit");

  ////////////////////////////////////////////////////////////////////////////
  // output checks

  halt_release_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !(cfg_q.stop_in_idle && device_idle) |=> !module_halt_q)
    else $error("module halted outside idle");

  clk_out_a: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1 |=> (module_clock_double_q == $past(cfg_q.module_clock_select)))
    else $error("clock select output stale");

  capture_pass_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (rx_msg && cfg_q.rx_capture_enable) |=> rx_capture_q)
    else $error("capture event missing");

  capture_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !rx_msg |=> !rx_capture_q)
    else $error("capture without receive");

  window_out_a: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1 |=> (filter_window_q == $past(cfg_q.filter_window)))
    else $error("window output stale");

  ////////////////////////////////////////////////////////////////////////////
  // mode checks

  mode_apply_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (bus_idle && mode_is_legal(requested_mode_q) && (requested_mode_q != cur_mode))
    |=> (cur_mode == $past(requested_mode_q)))
    else $error("mode not applied at bus idle");

  mode_same_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (requested_mode_q == cur_mode) |=> $stable(cur_mode))
    else $error("mode moved without new request");

  mode_legal_a: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1 |-> mode_is_legal(cur_mode))
    else $error("reserved mode in effect");

  mode_out_legal_a: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1 |-> mode_is_legal(current_mode_q))
    else $error("reserved mode reported");

endmodule : cmcr_top

// ### dv/cmcr_far_model.sv
/*
  far-side model: transmit buffers and bus traffic seen by the control register.
  assumes load and busy come from the bench, changed right after a rising edge.
*/
`timescale 1ns/1ps
module cmcr_far_model (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic abort_all_tx_q,
  input  wire logic load,
  input  wire logic busy,
  output logic      tx_pending,
  output logic      bus_idle
);
  logic [2:0] cnt_q;

  // a pending frame keeps the bus from being idle
  assign bus_idle = ~busy & ~tx_pending;

  // aborts take four cycles, so the abort bit is seen standing
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_pending <= 1'b0;
      cnt_q      <= 3'h0;
    end else if (load) begin
      tx_pending <= 1'b1;
      cnt_q      <= 3'h0;
    end else if (abort_all_tx_q && tx_pending) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h3) tx_pending <= 1'b0;
    end
  end
endmodule : cmcr_far_model

// ### dv/tb_cmcr_top.sv
/*
  testbench of the mode control register: register tasks and directed tests.
  assumes the far-side model and a 50 MHz clock.
*/
`timescale 1ns/1ps
module tb_cmcr_top;
  logic mclk = 0, rst_b = 0, rd = 0, wr = 0, dev_idle = 0, rx = 0, load = 0, busy = 0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic halt, abt, dbl, cap, win, pend, bidle;
  logic [2:0] cur;
  int num_errors = 0, comparisons = 0;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};

  always #10 mclk = ~mclk;

  cmcr_top cmcr_top_inst (.mclk(mclk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .device_idle(dev_idle), .bus_idle(bidle), .rx_msg(rx),
    .tx_pending(pend), .reg_rdata_q(rdata), .module_halt_q(halt), .abort_all_tx_q(abt),
    .module_clock_double_q(dbl), .rx_capture_q(cap), .filter_window_q(win),
    .current_mode_q(cur));
  cmcr_far_model cmcr_far_model_inst (.mclk(mclk), .rst_b(rst_b), .abort_all_tx_q(abt),
    .load(load), .busy(busy), .tx_pending(pend), .bus_idle(bidle));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_out(input logic [2:0] got, input logic [2:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t output %h expected %h", $time, got, exp);
    end
  endtask : chk_out

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    rd <= 1'b1; addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk_rd(rdata, exp);
  endtask : reg_read

  // one-cycle receive pulse, capture seen in the following cycle
  task automatic rx_pulse(input logic [2:0] exp);
    @(posedge mclk);
    rx <= 1'b1;
    @(posedge mclk);
    rx <= 1'b0;
    #1 chk_out(cap, exp);
  endtask : rx_pulse

  task automatic summarize();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    chk_out(cur, 3'h4);
    reg_read(4'h0, 16'h0480);
    @(posedge mclk) load <= 1'b1;
    @(posedge mclk) load <= 1'b0;
    reg_write(4'h0, 16'h1400);
    reg_read(4'h0, 16'h1480);
    chk_out({2'b0, abt}, 3'h1);
    for (int i = 0; i < 20 && abt !== 1'b0; i++) @(posedge mclk);
    reg_read(4'h0, 16'h0480);
    reg_write(4'h0, 16'hC416);
    reg_read(4'h0, 16'h0480);
    reg_write(4'h1, 16'hFFFF);
    reg_read(4'h1, 16'h0004);
    reg_read(4'hF, 16'h0000);
    busy <= 1'b1;
    reg_write(4'h0, 16'hFFFF);
    repeat (3) @(posedge mclk);
    reg_read(4'h0, 16'h2F89);
    chk_out({1'b0, dbl, win}, 3'h3);
    dev_idle <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk_out({2'b0, halt}, 3'h1);
    rx_pulse(3'h1);
    busy <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk_out(cur, 3'h7);
    foreach (modes[i]) begin
      reg_write(4'h0, {5'h00, modes[i], 8'h00});
      repeat (3) @(posedge mclk);
      #1 chk_out(cur, modes[i]);
      reg_read(4'h0, {5'h00, modes[i], modes[i], 5'h00});
    end
    for (int r = 5; r < 7; r++) begin
      reg_write(4'h0, {5'h00, 3'(r), 8'h00});
      repeat (3) @(posedge mclk);
      #1 chk_out(cur, 3'h4);
      reg_read(4'h0, {5'h00, 3'(r), 8'h80});
    end
    chk_out({2'b0, halt}, 3'h0);
    rx_pulse(3'h0);
    summarize();
  end
endmodule : tb_cmcr_top
